// [dacurc_pkg.sv]
// package: shared constants and carriers for the dac update and reset control block
package dacurc_pkg;

  localparam int unsigned CHANNELS_DEF = 8;                     // converter channel count
  localparam int unsigned DATA_W       = 12;                    // converter code width
  localparam int unsigned CHAN_IDX_W   = 3;                     // channel address width

  // reset codes of data register and latch
  localparam logic [11:0] CODE_ZERO    = 12'h000;
  localparam logic [11:0] CODE_MID     = 12'h800;
  // offset register reset codes, gain six, per data format
  localparam logic [11:0] OFFS_USB_G6  = 12'h099A;
  localparam logic [11:0] OFFS_BTC_G6  = 12'h019A;
  localparam logic [11:0] OFFS_OFF     = 12'h000;               // offset converter off, single supply
  // gain and zero defaults
  localparam logic [11:0] GAIN_DEF     = 12'hFFF;
  localparam logic [11:0] ZERO_DEF     = 12'h000;

  // correction engine delay, in clock cycles, per data register write
  localparam int unsigned ENG_CYCLES   = 4;

  // write request decoded from a serial word at chip select rise
  typedef struct packed {
    logic                  valid;   // one-cycle write strobe
    logic [CHAN_IDX_W-1:0] chan;    // addressed channel
    logic [DATA_W-1:0]     data;    // new code
  } dacurc_wr_t;

  // strap pins caught after power-on release; value and format straps again during hardware reset
  typedef struct packed {
    logic rst_sel;      // reset value select strap
    logic fmt_btc;      // data format select, high is twos complement
    logic dual_supply;  // supply mode, high is dual supply
  } dacurc_strap_t;

endpackage : dacurc_pkg

// [dacurc_sync.sv]
// module: two-flop synchroniser for one level input
`timescale 1ns/1ns
module dacurc_sync
  import dacurc_pkg::*;
#(
  parameter logic INIT = 1'b1     // level shown during reset
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  logic s1_r;   // first stage, read by second stage only
  logic s2_r;   // second stage
  logic s1_nxt;
  logic s2_nxt;

  // next values
  always_comb begin
    s1_nxt = din;
    s2_nxt = s1_r;
  end

  // stage registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= INIT;
      s2_r <= INIT;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign dout = s2_r;

endmodule : dacurc_sync

// [dacurc_engine.sv]
// module: correction engine model, delays each data register write by a fixed count
`timescale 1ns/1ns
module dacurc_engine
  import dacurc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       flush,     // abort pending work
  input  wire dacurc_wr_t req,       // raw write from serial decode
  output dacurc_wr_t      done,      // corrected write, one cycle
  output logic            busy       // work outstanding
);

  logic [2:0]  cnt_r;      // cycles left for current write
  logic [2:0]  cnt_nxt;
  dacurc_wr_t  hold_r;     // write in progress
  dacurc_wr_t  hold_nxt;
  dacurc_wr_t  done_r;
  dacurc_wr_t  done_nxt;

  // count down; a new request while busy restarts with the newer data
  // limitation: back to back words closer than the delay merge, fine for chip select rates
  always_comb begin
    cnt_nxt  = cnt_r;
    hold_nxt = hold_r;
    done_nxt = '0;
    if (flush) begin
      cnt_nxt  = '0;
      hold_nxt = '0;
    end else if (req.valid) begin
      cnt_nxt  = 3'(ENG_CYCLES);
      hold_nxt = req;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 3'd1;
      if (cnt_r == 3'd1) begin
        done_nxt = hold_r;
        hold_nxt = '0;
      end
    end
  end

  // engine state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      hold_r <= '0;
      done_r <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      hold_r <= hold_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign busy = (cnt_r != '0);

endmodule : dacurc_engine

// [dacurc_top.sv]
// module: latch update, clear and reset control for an eight channel converter
`timescale 1ns/1ns
module dacurc_top
  import dacurc_pkg::*;
#(
  parameter int unsigned CHANNELS = CHANNELS_DEF    // channel count
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,              // power-on reset
  input  wire logic                       hw_reset_n,           // hardware reset pin
  input  wire logic                       clear_outputs_n,      // clear pin
  input  wire logic                       latch_load_n,         // load strobe pin
  input  wire logic                       reset_value_select,   // strap
  input  wire logic                       data_format_select,   // strap, high twos complement
  input  wire logic                       dual_supply,          // supply mode strap
  input  wire logic                       correction_engine_enable,
  input  wire logic                       soft_load_bit,        // software load, level
  input  wire dacurc_wr_t                 word_in,              // decoded word, pulse at select rise
  output logic                            serial_enable,        // serial port allowed to run
  output logic                            sdo_oe,               // serial output drive enable
  output logic [CHANNELS-1:0]             out_clamp,            // pull-down path on per channel
  output logic [CHANNELS-1:0]             out_buf_en,           // output buffer driving per channel
  output logic [CHANNELS*DATA_W-1:0]      latch_codes,          // dac latch per channel
  output logic [CHANNELS*DATA_W-1:0]      data_codes,           // dac data register per channel
  output logic [DATA_W-1:0]               input_data,           // input data register
  output logic [DATA_W-1:0]               offset_code,          // offset dac register
  output logic [DATA_W-1:0]               gain_code,            // gain register
  output logic [DATA_W-1:0]               zero_code,            // zero register
  output logic                            sync_mode             // high when synchronous update
);

  // elaboration check: the channel field must address every channel
  if (CHANNELS < 1 || CHANNELS > (1 << CHAN_IDX_W)) begin : g_bad_channels
    $error("CHANNELS out of range");
  end

  // synchronised pins
  logic clr_n_s;   // clear
  logic rst_n_s;   // hardware reset
  logic ld_n_s;    // load strobe

  // asynchronous pins pass two flops first
  dacurc_sync #(.INIT(1'b1)) u_sync_clr (.clk(clk), .sys_rst(sys_rst), .din(clear_outputs_n), .dout(clr_n_s));
  dacurc_sync #(.INIT(1'b0)) u_sync_rst (.clk(clk), .sys_rst(sys_rst), .din(hw_reset_n),      .dout(rst_n_s));
  dacurc_sync #(.INIT(1'b1)) u_sync_ld  (.clk(clk), .sys_rst(sys_rst), .din(latch_load_n),    .dout(ld_n_s));

  // straps and mode captured after power-on release; value and format straps also follow the pins during hardware reset
  dacurc_strap_t strap_r;
  dacurc_strap_t strap_nxt;
  logic          caught_r;        // straps valid
  logic          caught_nxt;
  logic [1:0]    warm_r;          // edges since release, lets the pin synchronisers fill
  logic [1:0]    warm_nxt;
  logic          sync_mode_r;
  logic          sync_mode_nxt;

  // catch the mode once, third clock after release, never again
  // the load synchroniser shows its reset level for two edges, so earlier catching always reads synchronous
  always_comb begin
    strap_nxt     = strap_r;
    caught_nxt    = caught_r || (warm_r == 2'h2);
    warm_nxt      = caught_r ? warm_r : warm_r + 2'h1;
    sync_mode_nxt = sync_mode_r;
    if (!caught_r) begin
      // track pins until the freeze
      strap_nxt     = '{rst_sel: reset_value_select, fmt_btc: data_format_select, dual_supply: dual_supply};
      sync_mode_nxt = ld_n_s;
    end else if (!rst_n_s) begin
      // value and format straps follow the pins during hardware reset so new values apply; supply strap stays
      strap_nxt.rst_sel = reset_value_select;
      strap_nxt.fmt_btc = data_format_select;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_r     <= '0;
      caught_r    <= 1'b0;
      warm_r      <= 2'h0;
      sync_mode_r <= 1'b1;
    end else begin
      strap_r     <= strap_nxt;
      caught_r    <= caught_nxt;
      warm_r      <= warm_nxt;
      sync_mode_r <= sync_mode_nxt;
    end
  end

  // reset codes from straps
  logic [DATA_W-1:0] rst_data;
  logic [DATA_W-1:0] rst_offs;

  // xor of straps picks zero or mid code
  always_comb begin
    rst_data = (strap_r.rst_sel ^ strap_r.fmt_btc) ? CODE_MID : CODE_ZERO;
    if (!strap_r.dual_supply) begin
      rst_offs = OFFS_OFF;
    end else begin
      rst_offs = strap_r.fmt_btc ? OFFS_BTC_G6 : OFFS_USB_G6;
    end
  end

  // reset-like state: straps not yet caught or hardware reset held
  logic in_reset;
  assign in_reset = !caught_r || !rst_n_s;

  // correction engine
  dacurc_wr_t eng_done;
  logic       eng_busy;
  dacurc_wr_t word_gated;

  // words arriving during reset are dropped
  assign word_gated = in_reset ? '0 : word_in;

  dacurc_engine u_engine (
    .clk     (clk),
    .sys_rst (sys_rst),
    .flush   (in_reset),
    .req     (correction_engine_enable ? word_gated : '0),
    .done    (eng_done),
    .busy    (eng_busy)
  );

  // per channel registers
  logic [DATA_W-1:0] data_r   [CHANNELS];
  logic [DATA_W-1:0] data_nxt [CHANNELS];
  logic [DATA_W-1:0] latch_r  [CHANNELS];
  logic [DATA_W-1:0] latch_nxt[CHANNELS];
  logic [CHANNELS-1:0] pend_r;     // written since last load
  logic [CHANNELS-1:0] pend_nxt;
  logic [DATA_W-1:0] inp_r;
  logic [DATA_W-1:0] inp_nxt;
  logic [DATA_W-1:0] offs_r;
  logic [DATA_W-1:0] offs_nxt;
  logic [DATA_W-1:0] gain_r;
  logic [DATA_W-1:0] gain_nxt;
  logic [DATA_W-1:0] zero_r;
  logic [DATA_W-1:0] zero_nxt;
  logic              ld_prev_r;   // previous load strobe level
  logic              ld_prev_nxt;

  // effective write into data registers
  dacurc_wr_t wr_eff;
  logic       load_req;   // sync mode commit request
  logic       load_go;    // commit now

  // with engine on, the data register is written when the engine finishes
  always_comb begin
    wr_eff   = correction_engine_enable ? eng_done : word_gated;
    // load is ignored while clear is low, and fully in async mode
    load_req = sync_mode_r && clr_n_s && (!ld_n_s || soft_load_bit);
    // with engine on wait for engine idle and no write landing this cycle
    load_go  = load_req && !(correction_engine_enable && (eng_busy || eng_done.valid));
  end

  // register next values; clear touches none of these
  always_comb begin
    inp_nxt     = inp_r;
    offs_nxt    = offs_r;
    gain_nxt    = gain_r;
    zero_nxt    = zero_r;
    pend_nxt    = pend_r;
    ld_prev_nxt = ld_n_s;
    for (int i = 0; i < CHANNELS; i++) begin
      data_nxt[i]  = data_r[i];
      latch_nxt[i] = latch_r[i];
    end
    if (in_reset) begin
      // hold strap values and defaults while reset is low
      inp_nxt  = ZERO_DEF;
      offs_nxt = rst_offs;
      gain_nxt = GAIN_DEF;
      zero_nxt = ZERO_DEF;
      pend_nxt = '0;
      for (int i = 0; i < CHANNELS; i++) begin
        data_nxt[i]  = rst_data;
        latch_nxt[i] = rst_data;
      end
    end else begin
      // values stay until written
      if (load_go) begin
        // simultaneous update of pending or all channels
        for (int i = 0; i < CHANNELS; i++) begin
          if (pend_r[i] || soft_load_bit) begin
            latch_nxt[i] = data_r[i];
          end
        end
        pend_nxt = '0;
      end
      // no load in sync mode leaves latches alone
      if (wr_eff.valid && 32'(wr_eff.chan) < CHANNELS) begin
        data_nxt[wr_eff.chan] = wr_eff.data;
        inp_nxt               = wr_eff.data;
        if (!sync_mode_r) begin
          // async: latch follows data at once, only the written channel
          latch_nxt[wr_eff.chan] = wr_eff.data;
        end else begin
          // a write in the commit cycle stays pending, set wins over clear
          pend_nxt[wr_eff.chan] = 1'b1;
        end
      end
    end
  end

  // register state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inp_r     <= 12'h0000;
      offs_r    <= 12'h0000;
      gain_r    <= 12'h0000;
      zero_r    <= 12'h0000;
      pend_r    <= '0;
      ld_prev_r <= 1'b1;
      for (int i = 0; i < CHANNELS; i++) begin
        data_r[i]  <= 12'h0000;
        latch_r[i] <= 12'h0000;
      end
    end else begin
      inp_r     <= inp_nxt;
      offs_r    <= offs_nxt;
      gain_r    <= gain_nxt;
      zero_r    <= zero_nxt;
      pend_r    <= pend_nxt;
      ld_prev_r <= ld_prev_nxt;
      for (int i = 0; i < CHANNELS; i++) begin
        data_r[i]  <= data_nxt[i];
        latch_r[i] <= latch_nxt[i];
      end
    end
  end

  // clear-hold: set by clear low, released by clear high plus load low
  logic cleared_r;
  logic cleared_nxt;

  // release on load low covers the tied-low case at once
  always_comb begin
    cleared_nxt = cleared_r;
    if (!clr_n_s) begin
      cleared_nxt = 1'b1;
    end else if (!ld_n_s || !sync_mode_r) begin
      // async mode treats load as tied low
      cleared_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cleared_r <= 1'b0;
    end else begin
      cleared_r <= cleared_nxt;
    end
  end

  // output registers
  logic [CHANNELS-1:0]        clamp_r;
  logic [CHANNELS-1:0]        buf_r;
  logic [CHANNELS*DATA_W-1:0] lcodes_r;
  logic [CHANNELS*DATA_W-1:0] dcodes_r;
  logic                       ser_en_r;
  logic                       sdo_oe_r;

  // per channel output shaping
  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          clamp_r[g]                     <= 1'b1;
          buf_r[g]                       <= 1'b0;
          lcodes_r[g*DATA_W +: DATA_W]   <= 12'h0000;
          dcodes_r[g*DATA_W +: DATA_W]   <= 12'h0000;
        end else begin
          clamp_r[g]                     <= cleared_nxt;
          buf_r[g]                       <= !cleared_nxt;
          lcodes_r[g*DATA_W +: DATA_W]   <= latch_nxt[g];
          dcodes_r[g*DATA_W +: DATA_W]   <= data_nxt[g];
        end
      end
    end
  endgenerate

  // serial port held off during reset; sdo drive enable held low at all times
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_en_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      ser_en_r <= caught_nxt && rst_n_s;
      sdo_oe_r <= 1'b0;   // serial output stays quiet here; shifter owns its own drive
    end
  end

  assign out_clamp     = clamp_r;
  assign out_buf_en    = buf_r;
  assign latch_codes   = lcodes_r;
  assign data_codes    = dcodes_r;
  assign input_data    = inp_r;
  assign offset_code   = offs_r;
  assign gain_code     = gain_r;
  assign zero_code     = zero_r;
  assign serial_enable = ser_en_r;
  assign sdo_oe        = sdo_oe_r;
  assign sync_mode     = sync_mode_r;

  // assertions
  a_clear_forces_out: assert property (@(posedge clk) disable iff (sys_rst)
    !clr_n_s |=> out_clamp == '1 && out_buf_en == '0) else $error("clear did not force outputs");
  a_clear_keeps_latch: assert property (@(posedge clk) disable iff (sys_rst)
    !clr_n_s && $past(!clr_n_s) && rst_n_s && caught_r && sync_mode_r && !wr_eff.valid
    |=> $stable(latch_codes)) else $error("latch moved under clear");
  a_reset_input_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_n_s |=> input_data == 12'h0000) else $error("input register not cleared");
  a_reset_blocks_ser: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_n_s |=> !serial_enable && !sdo_oe) else $error("serial active in reset");
  a_reset_gain_def: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_n_s |=> gain_code == GAIN_DEF && zero_code == ZERO_DEF) else $error("gain zero not default");
  a_mode_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    caught_r |=> $stable(sync_mode)) else $error("mode changed after power-on");
  a_sync_no_load: assert property (@(posedge clk) disable iff (sys_rst)
    sync_mode_r && caught_r && rst_n_s && ld_n_s && !soft_load_bit |=> $stable(latch_codes))
    else $error("latch moved without load");
  a_offs_dual_usb: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_n_s && strap_r.dual_supply && !strap_r.fmt_btc |=> offset_code == OFFS_USB_G6)
    else $error("offset reset wrong");
  a_async_immediate: assert property (@(posedge clk) disable iff (sys_rst)
    !sync_mode_r && !in_reset && word_in.valid && !correction_engine_enable && word_in.chan == 3'd0
    |=> latch_codes[DATA_W-1:0] == $past(word_in.data)) else $error("async latch late");
  a_engine_then_load: assert property (@(posedge clk) disable iff (sys_rst)
    load_go |-> !(correction_engine_enable && eng_busy)) else $error("load before engine done");

endmodule : dacurc_top

// [dacurc_host_model.sv]
// file: host controller model driving reset, clear, load and decoded write lines
`timescale 1ns/1ns
module dacurc_host_model
  import dacurc_pkg::*;
#(
  parameter int unsigned T9_CYCLES = 2          // settle gap after select rise, plain default
) (
  input  wire logic  clk,
  input  wire logic  serial_enable,
  output logic       hw_reset_n,
  output logic       clear_outputs_n,
  output logic       latch_load_n,
  output logic       soft_load_bit,
  output dacurc_wr_t word_in
);
  // idle levels at time zero; idle data is a pattern, never a real code
  initial begin
    hw_reset_n      = 1'b1;
    clear_outputs_n = 1'b1;
    latch_load_n    = 1'b1;
    soft_load_bit   = 1'b0;
    word_in         = '{valid: 1'b0, chan: 3'h5, data: 12'ha5a};
  end

  // pin levels, called just after a falling edge
  task automatic drive(input logic rst_n, input logic clr_n, input logic ld_n);
    hw_reset_n      = rst_n;
    clear_outputs_n = clr_n;
    latch_load_n    = ld_n;
  endtask : drive

  // one write per select rise; select stays high while the part is in reset
  task automatic send_word(input logic [2:0] ch, input logic [11:0] d);
    int unsigned n;
    n = 0;
    while (serial_enable !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    word_in = '{valid: 1'b1, chan: ch, data: d};
    @(negedge clk);
    // released lines show the inverse, so stale data never looks valid
    word_in = '{valid: 1'b0, chan: ~ch, data: ~d};
    repeat (T9_CYCLES) @(negedge clk);
  endtask : send_word

  // load strobe low for hold cycles, then high for two cycles
  task automatic pulse_load(input int unsigned hold);
    latch_load_n = 1'b0;
    repeat (hold) @(negedge clk);
    latch_load_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : pulse_load

  // software load as a short level
  task automatic soft_load();
    soft_load_bit = 1'b1;
    repeat (4) @(negedge clk);
    soft_load_bit = 1'b0;
    repeat (2) @(negedge clk);
  endtask : soft_load
endmodule : dacurc_host_model

// [dacurc_tb.sv]
// file: self-checking testbench for the update, clear and reset control
`timescale 1ns/1ns
module testbench
  import dacurc_pkg::*;
();
  // one reset row: straps beside expected codes
  typedef struct packed {
    logic        dual;
    logic        sel;
    logic        fmt;
    logic [11:0] code;
    logic [11:0] offs;
  } dacurc_row_t;

  localparam dacurc_row_t ROWS [8] = '{
    '{1'b0, 1'b0, 1'b0, 12'h000, 12'h000},
    '{1'b0, 1'b1, 1'b0, 12'h800, 12'h000},
    '{1'b0, 1'b0, 1'b1, 12'h800, 12'h000},
    '{1'b0, 1'b1, 1'b1, 12'h000, 12'h000},
    '{1'b1, 1'b0, 1'b0, 12'h000, 12'h99a},
    '{1'b1, 1'b1, 1'b0, 12'h800, 12'h99a},
    '{1'b1, 1'b0, 1'b1, 12'h800, 12'h19a},
    '{1'b1, 1'b1, 1'b1, 12'h000, 12'h19a}
  };

  logic        clk;                      // 100 MHz
  logic        sys_rst;                  // power-on reset
  logic        dual_supply;              // straps
  logic        reset_value_select;
  logic        data_format_select;
  logic        correction_engine_enable;
  logic        hw_reset_n;               // host driven
  logic        clear_outputs_n;
  logic        latch_load_n;
  logic        soft_load_bit;
  dacurc_wr_t  word_in;
  logic        serial_enable;            // design outputs
  logic        sdo_oe;
  logic [7:0]  out_clamp;
  logic [7:0]  out_buf_en;
  logic [95:0] latch_codes;
  logic [95:0] data_codes;
  logic [11:0] input_data;
  logic [11:0] offset_code;
  logic [11:0] gain_code;
  logic [11:0] zero_code;
  logic        sync_mode;
  int          err_count;
  int          comparisons;

  dacurc_top #(.CHANNELS(8)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n), .clear_outputs_n(clear_outputs_n),
    .latch_load_n(latch_load_n), .reset_value_select(reset_value_select),
    .data_format_select(data_format_select), .dual_supply(dual_supply),
    .correction_engine_enable(correction_engine_enable), .soft_load_bit(soft_load_bit),
    .word_in(word_in), .serial_enable(serial_enable), .sdo_oe(sdo_oe), .out_clamp(out_clamp),
    .out_buf_en(out_buf_en), .latch_codes(latch_codes), .data_codes(data_codes),
    .input_data(input_data), .offset_code(offset_code), .gain_code(gain_code),
    .zero_code(zero_code), .sync_mode(sync_mode)
  );

  dacurc_host_model #(.T9_CYCLES(2)) host_u (
    .clk(clk), .serial_enable(serial_enable), .hw_reset_n(hw_reset_n),
    .clear_outputs_n(clear_outputs_n), .latch_load_n(latch_load_n),
    .soft_load_bit(soft_load_bit), .word_in(word_in)
  );

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // channel slices of the wide code buses
  function automatic logic [11:0] lat(input int ch);
    return latch_codes[ch*12 +: 12];
  endfunction : lat
  function automatic logic [11:0] dat(input int ch);
    return data_codes[ch*12 +: 12];
  endfunction : dat

  // code compare
  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_code

  // flag and per-channel vector compare
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bits

  // power-on reset with straps; load level must settle well before release
  task automatic por(input logic dual, input logic sel, input logic fmt, input logic ld_n);
    @(negedge clk);
    sys_rst            = 1'b1;
    dual_supply        = dual;
    reset_value_select = sel;
    data_format_select = fmt;
    host_u.drive(1'b1, 1'b1, ld_n);
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
  endtask : por

  // single exit: counts, verdict, end of run
  task automatic tally_and_finish();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog, far beyond the roughly 220 cycles the tests need
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    correction_engine_enable = 1'b0;
    // strap rows, synchronous mode
    foreach (ROWS[i]) begin
      por(ROWS[i].dual, ROWS[i].sel, ROWS[i].fmt, 1'b1);
      chk_code(lat(0), ROWS[i].code);
      chk_code(dat(7), ROWS[i].code);
      chk_code(offset_code, ROWS[i].offs);
      chk_code(gain_code, 12'hfff);
      chk_code(zero_code, 12'h000);
      chk_code(input_data, 12'h000);
      chk_bits({7'h00, sync_mode}, 8'h01);
    end
    $display("test strap rows done");
    // synchronous write, hold, strobe and software load
    host_u.send_word(3'h2, 12'h123);
    chk_code(dat(2), 12'h123);
    chk_code(input_data, 12'h123);
    repeat (8) @(negedge clk);
    chk_code(lat(2), 12'h000);
    host_u.pulse_load(4);
    chk_code(lat(2), 12'h123);
    chk_code(lat(3), 12'h000);
    host_u.send_word(3'h3, 12'h456);
    host_u.send_word(3'h4, 12'h789);
    host_u.soft_load();
    chk_code(lat(3), 12'h456);
    chk_code(lat(4), 12'h789);
    $display("test sync load done");
    // clear: strobes ignored, stays cleared after release until a strobe
    host_u.drive(1'b1, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk_bits(out_clamp, 8'hff);
    chk_bits(out_buf_en, 8'h00);
    host_u.send_word(3'h5, 12'habc);
    host_u.pulse_load(4);
    chk_code(lat(5), 12'h000);
    chk_code(dat(5), 12'habc);
    chk_code(lat(2), 12'h123);
    host_u.drive(1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge clk);
    chk_bits(out_clamp, 8'hff);
    host_u.pulse_load(4);
    chk_bits(out_clamp, 8'h00);
    chk_bits(out_buf_en, 8'hff);
    chk_code(lat(5), 12'habc);
    $display("test clear done");
    // hardware reset in mid-run, then resume
    host_u.drive(1'b0, 1'b1, 1'b1);
    repeat (6) @(negedge clk);
    chk_bits({7'h00, serial_enable}, 8'h00);
    chk_bits({7'h00, sdo_oe}, 8'h00);
    chk_code(lat(2), 12'h000);
    chk_code(dat(5), 12'h000);
    chk_code(input_data, 12'h000);
    host_u.drive(1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge clk);
    chk_bits({7'h00, serial_enable}, 8'h01);
    chk_code(lat(4), 12'h000);
    host_u.send_word(3'h1, 12'h321);
    chk_code(dat(1), 12'h321);
    $display("test hardware reset done");
    // asynchronous mode: load tied low before power-on
    por(1'b1, 1'b0, 1'b0, 1'b0);
    chk_bits({7'h00, sync_mode}, 8'h00);
    host_u.send_word(3'h6, 12'h654);
    chk_code(lat(6), 12'h654);
    host_u.drive(1'b1, 1'b1, 1'b1);
    host_u.send_word(3'h0, 12'h111);
    chk_code(lat(0), 12'h111);
    host_u.drive(1'b1, 1'b1, 1'b0);
    correction_engine_enable = 1'b1;
    host_u.send_word(3'h7, 12'h777);
    chk_code(lat(7), 12'h000);
    repeat (5) @(negedge clk);
    chk_code(lat(7), 12'h777);
    host_u.drive(1'b1, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk_bits(out_clamp, 8'hff);
    host_u.drive(1'b1, 1'b1, 1'b0);
    repeat (4) @(negedge clk);
    chk_bits(out_buf_en, 8'hff);
    chk_code(lat(7), 12'h777);
    $display("test async done");
    // synchronous mode with engine: strobe waits for the engine
    por(1'b0, 1'b1, 1'b0, 1'b1);
    host_u.send_word(3'h3, 12'h0ab);
    host_u.drive(1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk_code(lat(3), 12'h800);
    host_u.pulse_load(10);
    chk_code(lat(3), 12'h0ab);
    $display("test sync engine done");
    correction_engine_enable = 1'b0;
    tally_and_finish();
  end
endmodule : testbench
